// ---- hdl/asis_top.sv ----
// apb slave holding the sequence input select register plus run control and status
// assumes apb3 master on the same clock; converter acks each request with convDone
`timescale 1ns/1ps
// Overview of operation
// R1: slot one input from bits 2:0
// R2: slot two input from bits 6:4
// R3: slot three input from bits 10:8
// R4: slot four input from bits 14:12
// R5: slot five input from bits 18:16
// R6: slot six input from bits 22:20
// R7: slot seven input from bits 26:24
// R8: slot eight input from bits 30:28
// R9: field value n selects channel n
// R10: reserved bits read-only, read zero
// R11: software preserves reserved bits on update
// R12: field read when its slot issues
module asis_top
   import asis_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic convDone,
   output logic convReq,
   output logic [SEL_W-1:0] convChannel
);
   asis_reg_if rif ();
   logic [31:0] sel_r, sel_nxt;
   logic [SLOT_W-1:0] len_r, len_nxt;
   logic start_r, start_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt;
   logic err_r, err_nxt;
   logic access;
   logic hitSel, hitCtrl, hitStat;

   assign access = psel && penable && !ready_r;
   assign hitSel = paddr == SEQ_SEL_OFFSET;
   assign hitCtrl = paddr == SLOT_CTRL_OFFSET;
   assign hitStat = paddr == SLOT_STAT_OFFSET;

   // one wait state: answer registered, pready high on second access cycle
   always_comb begin
      sel_nxt = sel_r;
      len_nxt = len_r;
      start_nxt = 1'b0;
      rdata_nxt = rdata_r;
      ready_nxt = 1'b0;
      err_nxt = 1'b0;
      if (access) begin
         ready_nxt = 1'b1;
         err_nxt = !(hitSel || hitCtrl || hitStat);
         rdata_nxt = ZERO_WORD;
         if (pwrite) begin
            if (hitSel) begin
               sel_nxt = pwdata & SEQ_SEL_WMASK; // [R10] [R11]
            end
            if (hitCtrl) begin
               len_nxt = pwdata[CTRL_LEN_LSB +: SLOT_W];
               start_nxt = pwdata[CTRL_START_BIT] && !rif.busy;
            end
         end else begin
            if (hitSel) begin
               rdata_nxt = sel_r; // [R10]
            end
            if (hitCtrl) begin
               rdata_nxt[CTRL_LEN_LSB +: SLOT_W] = len_r;
            end
            if (hitStat) begin
               rdata_nxt[STAT_BUSY_BIT] = rif.busy;
               rdata_nxt[STAT_SLOT_LSB +: SLOT_W] = rif.curSlot;
               rdata_nxt[STAT_SEL_LSB +: SEL_W] = rif.curSel;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sel_r <= SEQ_SEL_RESET;
         len_r <= '1;
         start_r <= 1'b0;
         rdata_r <= ZERO_WORD;
         ready_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         sel_r <= sel_nxt;
         len_r <= len_nxt;
         start_r <= start_nxt;
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         err_r <= err_nxt;
      end
   end

   assign prdata = rdata_r;
   assign pready = ready_r;
   assign pslverr = err_r;
   assign rif.selWord = sel_r; // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8]
   assign rif.startPulse = start_r;
   assign rif.lastSlot = len_r;

   asis_seq_core uCore (
      .clock(clock),
      .rst_b(rst_b),
      .rif(rif.core),
      .convDone(convDone),
      .convReq(convReq),
      .convChannel(convChannel)
   );

   property p_reserved_zero;
      @(posedge clock) disable iff (!rst_b)
      (sel_r & ~SEQ_SEL_WMASK) == ZERO_WORD;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved select bits not zero"); // [R10]

   property p_write_lands;
      @(posedge clock) disable iff (!rst_b)
      access && pwrite && hitSel |=> sel_r == ($past(pwdata) & SEQ_SEL_WMASK);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("select write lost"); // [R1]

   property p_read_back;
      @(posedge clock) disable iff (!rst_b)
      access && !pwrite && hitSel |=> pready && prdata == $past(sel_r);
   endproperty
   a_read_back: assert property (p_read_back) else $error("select readback wrong"); // [R10]

   property p_one_wait;
      @(posedge clock) disable iff (!rst_b)
      psel && !penable ##1 psel && penable |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready late"); // [R10]

   sequence s_unmapped;
      access && !(hitSel || hitCtrl || hitStat);
   endsequence
   property p_unmapped_err;
      @(posedge clock) disable iff (!rst_b)
      s_unmapped |=> pready && pslverr && prdata == ZERO_WORD;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused"); // [R10]

   sequence s_mapped;
      access && (hitSel || hitCtrl || hitStat);
   endsequence
   property p_mapped_ok;
      @(posedge clock) disable iff (!rst_b)
      s_mapped |=> pready && !pslverr;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged as error"); // [R10]

   // a start written mid run must not restart the walk
   property p_busy_start;
      @(posedge clock) disable iff (!rst_b)
      access && pwrite && hitCtrl && rif.busy |=> !rif.startPulse;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("start taken while busy"); // [R12]
endmodule : asis_top

// ---- pkg/asis_pkg.sv ----
// package for the sequence input select block: register map, field layout, reset values
// assumes a 32-bit apb register bus and an eight-slot sample sequencer
package asis_pkg;
   localparam int unsigned NUM_SLOTS = 8;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned SLOT_W = 3;
   localparam int unsigned FIELD_STRIDE = 4;
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] SEQ_SEL_OFFSET = 12'h040;
   localparam logic [11:0] SLOT_CTRL_OFFSET = 12'h048;
   localparam logic [11:0] SLOT_STAT_OFFSET = 12'h04c;
   localparam logic [31:0] SEQ_SEL_RESET = 32'h0000_0000;
   localparam logic [31:0] SEQ_SEL_WMASK = 32'h7777_7777;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_LEN_LSB = 4;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_SLOT_LSB = 4;
   localparam int unsigned STAT_SEL_LSB = 8;
   typedef enum logic [1:0] {
      ASIS_IDLE = 2'b00,
      ASIS_ISSUE = 2'b01,
      ASIS_WAIT = 2'b10
   } asis_state_t;
endpackage : asis_pkg

// ---- pkg/asis_reg_if.sv ----
// carrier between the apb slave and the sequence core
// assumes one clock for both ends
`timescale 1ns/1ps
interface asis_reg_if;
   import asis_pkg::*;
   logic [31:0] selWord;
   logic startPulse;
   logic [SLOT_W-1:0] lastSlot;
   logic busy;
   logic [SLOT_W-1:0] curSlot;
   logic [SEL_W-1:0] curSel;
   modport regs (output selWord, output startPulse, output lastSlot, input busy, input curSlot, input curSel);
   modport core (input selWord, input startPulse, input lastSlot, output busy, output curSlot, output curSel);
endinterface : asis_reg_if

// ---- hdl/asis_slot_pick.sv ----
// picks the select field of one sample slot from the select word
// assumes fields are SEL_W wide on a FIELD_STRIDE grid
`timescale 1ns/1ps
module asis_slot_pick
   import asis_pkg::*;
(
   input wire logic [31:0] selWord,
   input wire logic [SLOT_W-1:0] slot,
   output logic [SEL_W-1:0] sel
);
   always_comb begin
      sel = selWord[slot*FIELD_STRIDE +: SEL_W]; // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8]
   end
endmodule : asis_slot_pick

// ---- hdl/asis_seq_core.sv ----
// walks the sample slots and hands each slot's input select to the converter
// assumes the converter acknowledges each request with a one-cycle convDone
`timescale 1ns/1ps
module asis_seq_core
   import asis_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   asis_reg_if.core rif,
   input wire logic convDone,
   output logic convReq,
   output logic [SEL_W-1:0] convChannel
);
   asis_state_t state_r, state_nxt;
   logic [SLOT_W-1:0] slot_r, slot_nxt;
   logic [SEL_W-1:0] chan_r, chan_nxt;
   logic req_r, req_nxt;
   logic [SEL_W-1:0] pickSel;

   asis_slot_pick uPick (.selWord(rif.selWord), .slot(slot_r), .sel(pickSel));

   always_comb begin
      state_nxt = state_r;
      slot_nxt = slot_r;
      chan_nxt = chan_r;
      req_nxt = 1'b0;
      unique case (state_r)
         ASIS_IDLE: begin
            if (rif.startPulse) begin
               slot_nxt = '0;
               state_nxt = ASIS_ISSUE;
            end
         end
         ASIS_ISSUE: begin
            // field sampled only now, so later writes hit later slots
            chan_nxt = pickSel; // [R9] [R12]
            req_nxt = 1'b1;
            state_nxt = ASIS_WAIT;
         end
         ASIS_WAIT: begin
            if (convDone) begin
               if (slot_r == rif.lastSlot) begin
                  state_nxt = ASIS_IDLE;
               end else begin
                  slot_nxt = slot_r + 1'b1;
                  state_nxt = ASIS_ISSUE;
               end
            end
         end
         default: state_nxt = ASIS_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ASIS_IDLE;
         slot_r <= '0;
         chan_r <= '0;
         req_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         slot_r <= slot_nxt;
         chan_r <= chan_nxt;
         req_r <= req_nxt;
      end
   end

   assign convReq = req_r;
   assign convChannel = chan_r;
   assign rif.busy = (state_r != ASIS_IDLE);
   assign rif.curSlot = slot_r;
   assign rif.curSel = chan_r;

   // compare against the word as it stood at issue: a write landing on that edge belongs to later slots
   property p_chan_from_field;
      @(posedge clock) disable iff (!rst_b)
      state_r == ASIS_ISSUE |=> convReq && convChannel == $past(rif.selWord[slot_r*FIELD_STRIDE +: SEL_W]);
   endproperty
   a_chan_from_field: assert property (p_chan_from_field) else $error("channel not from slot field"); // [R12]

   sequence s_req;
      convReq;
   endsequence
   property p_chan_stable;
      @(posedge clock) disable iff (!rst_b)
      s_req ##1 !convDone |-> $stable(convChannel);
   endproperty
   a_chan_stable: assert property (p_chan_stable) else $error("channel moved mid conversion"); // [R9]

   sequence s_done_mid;
      state_r == ASIS_WAIT && convDone && slot_r != rif.lastSlot;
   endsequence
   property p_slot_order;
      @(posedge clock) disable iff (!rst_b)
      s_done_mid |=> state_r == ASIS_ISSUE && slot_r == $past(slot_r) + 3'h1;
   endproperty
   a_slot_order: assert property (p_slot_order) else $error("slot skipped or repeated"); // [R12]

   sequence s_done_last;
      state_r == ASIS_WAIT && convDone && slot_r == rif.lastSlot;
   endsequence
   property p_last_stops;
      @(posedge clock) disable iff (!rst_b)
      s_done_last |=> state_r == ASIS_IDLE;
   endproperty
   a_last_stops: assert property (p_last_stops) else $error("sequence ran past last slot"); // [R12]
endmodule : asis_seq_core

// ---- verif/tb.sv ----
// self-checking bench for the sequence input select block
// assumes registered apb answers and one convReq per slot, acked by convDone
`timescale 1ns/1ps
module tb;
   import asis_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic convDone = 1'b0;
   logic convReq;
   logic [SEL_W-1:0] convChannel;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int num_checks = 0;

   always #5 clock = ~clock;

   asis_top asis_top_inst (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convDone(convDone), .convReq(convReq), .convChannel(convChannel));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // request held until the edge that samples pready high
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      check({31'h0, pready}, 32'h1, "apb answer");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // request and channel are checked together so a missing request cannot pass
   task automatic wait_req(input logic [2:0] expCh);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (convReq !== 1'b1 && n < 50);
      check({28'h0, convReq, convChannel}, {28'h0, 1'b1, expCh}, "slot request");
   endtask : wait_req

   task automatic ack();
      convDone <= 1'b1;
      @(posedge clock);
      convDone <= 1'b0;
   endtask : ack

   task automatic test_reset();
      apb(1'b0, SEQ_SEL_OFFSET, 32'h0000_0000);
      check(rd, 32'h0000_0000, "select reset");
      check({31'h0, err}, 32'h0, "select read error flag");
      $display("test reset done");
   endtask : test_reset

   task automatic test_reserved();
      apb(1'b1, SEQ_SEL_OFFSET, 32'hffff_ffff);
      apb(1'b0, SEQ_SEL_OFFSET, 32'h0000_0000);
      check(rd, 32'h7777_7777, "reserved bits");
      apb(1'b1, SEQ_SEL_OFFSET, rd & 32'h7777_0777);
      apb(1'b0, SEQ_SEL_OFFSET, 32'h0000_0000);
      check(rd, 32'h7777_0777, "read modify write");
      $display("test reserved done");
   endtask : test_reserved

   task automatic test_unmapped();
      apb(1'b0, 12'h100, 32'h0000_0000);
      check({rd[30:0], err}, 32'h1, "unmapped read");
      $display("test unmapped done");
   endtask : test_unmapped

   // a write while slot 3 waits must only steer slots 4 to 7
   task automatic test_sequence();
      logic [31:0] oldW;
      logic [31:0] newW;
      oldW = 32'h0123_4567;
      newW = 32'h7060_5040;
      apb(1'b1, SEQ_SEL_OFFSET, oldW);
      apb(1'b1, SLOT_CTRL_OFFSET, 32'h0000_0071);
      for (int k = 0; k < 8; k++) begin
         wait_req(k < 4 ? oldW[4*k +: 3] : newW[4*k +: 3]);
         if (k == 3) begin
            apb(1'b0, SLOT_STAT_OFFSET, 32'h0000_0000);
            check(rd, 32'h0000_0431, "status mid sequence");
            apb(1'b1, SLOT_CTRL_OFFSET, 32'h0000_0071);
            apb(1'b1, SEQ_SEL_OFFSET, newW);
         end
         ack();
      end
      $display("test sequence done");
   endtask : test_sequence

   // short run: only slots 0 to 2, then silence
   task automatic test_short();
      logic [31:0] w;
      w = 32'h0000_0536;
      apb(1'b1, SEQ_SEL_OFFSET, w);
      apb(1'b1, SLOT_CTRL_OFFSET, 32'h0000_0021);
      for (int k = 0; k < 3; k++) begin
         wait_req(w[4*k +: 3]);
         ack();
      end
      repeat (20) begin
         @(posedge clock);
         check({31'h0, convReq}, 32'h0, "request after last slot");
      end
      apb(1'b0, SLOT_CTRL_OFFSET, 32'h0000_0000);
      check(rd, 32'h0000_0020, "control readback");
      apb(1'b0, SLOT_STAT_OFFSET, 32'h0000_0000);
      check(rd, 32'h0000_0520, "status after run");
      $display("test short done");
   endtask : test_short

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      test_reset();
      test_reserved();
      test_unmapped();
      test_sequence();
      test_short();
      report_and_stop();
   end

   // whole run needs well under 2000 cycles
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
endmodule : tb
